/* File: hw/pcs_serial_port.sv */
// PCM serial port, serial control port and transmit FIFO
`timescale 1ns/1ps

// ---------------------------------------------------------------
// Transmit FIFO
// ---------------------------------------------------------------
module pcs_fifo #(
  parameter int W = 8,
  parameter int D = 4
) (
  input  wire logic         core_clk,
  input  wire logic         rstn,
  input  wire logic [W-1:0] in_data,
  input  wire logic         in_valid,
  output logic              in_ready,
  output logic [W-1:0]      out_data,
  output logic              out_valid,
  input  wire logic         out_ready
);
  localparam int AW = (D > 1) ? $clog2(D) : 1;
  localparam int CW = $clog2(D + 1);

  logic [W-1:0]  mem [D];
  logic [AW-1:0] wp_r;
  logic [AW-1:0] rp_r;
  logic [CW-1:0] cnt_r;
  logic          push;
  logic          pop;

  // Refuse sizes the pointer logic cannot serve
  if (D < 2 || W < 1) begin : g_bad_size
    $error("pcs_fifo: depth below 2 or width below 1");
  end

  // Handshake terms
  assign in_ready  = (cnt_r != CW'(D));
  assign out_valid = (cnt_r != '0);
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;
  assign out_data  = mem[rp_r];

  // Storage
  always_ff @(posedge core_clk) begin
    if (push) begin
      mem[wp_r] <= in_data;
    end
  end

  // Pointers and fill level
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      wp_r  <= '0;
      rp_r  <= '0;
      cnt_r <= '0;
    end else begin
      if (push) begin
        wp_r <= (wp_r == AW'(D - 1)) ? '0 : wp_r + 1'b1;
      end
      if (pop) begin
        rp_r <= (rp_r == AW'(D - 1)) ? '0 : rp_r + 1'b1;
      end
      if (push && !pop) begin
        cnt_r <= cnt_r + 1'b1;
      end else if (pop && !push) begin
        cnt_r <= cnt_r - 1'b1;
      end
    end
  end
endmodule // pcs_fifo

// ---------------------------------------------------------------
// Port top
// ---------------------------------------------------------------
module pcs_serial_port
  import pcs_pkg::*;
#(
  parameter int DEPTH = FIFO_DEPTH,
  parameter int LN    = LATCH_N
) (
  input  wire logic          core_clk,
  input  wire logic          rstn,
  input  wire logic          pcm_bclk,
  input  wire logic          tx_frame_sync,
  input  wire logic          rx_frame_sync,
  input  wire logic [1:0]    pcm_rx_data,
  output logic               pcm_tx_data,
  output logic               pcm_tx_data_oe_n,
  output logic               tx_slot_indicator_n,
  input  wire logic          delayed_mode,
  input  wire logic          rx_port_sel,
  input  wire logic [7:0]    tx_word,
  input  wire logic          tx_valid,
  output logic               tx_ready,
  output logic [7:0]         rx_word,
  output logic               rx_valid,
  input  wire logic          control_clock,
  input  wire logic          control_select_n,
  input  wire logic          control_in,
  output logic               control_out,
  output logic               control_out_oe_n,
  output logic [7:0]         cmd_byte,
  output logic               cmd_valid,
  output logic [7:0]         ctl_wdata,
  output logic               ctl_wvalid,
  input  wire logic [7:0]    ctl_resp,
  input  wire logic [LN-1:0] latch_dir,
  input  wire logic [LN-1:0] interface_latch_pin_in,
  output logic [LN-1:0]      interface_latch_pin_out,
  output logic [LN-1:0]      interface_latch_pin_oe_n,
  output logic [LN-1:0]      latch_sample
);
  // Latch outputs are taken from one data byte
  if (LN < 1 || LN > BYTE_W) begin : g_bad_latch
    $error("pcs_serial_port: latch count out of range");
  end

  // ---------------------------------------------------------------
  // Pin synchronisers and edge detection
  // ---------------------------------------------------------------
  logic [7:0]    s1_r;
  logic [7:0]    s2_r;
  logic [7:0]    s3_r;
  logic [LN-1:0] l1_r;
  logic [LN-1:0] l2_r;

  // Two stages, third only for edges
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      s1_r <= 8'h02; // Idle pin levels: only select high
      s2_r <= 8'h02;
      s3_r <= 8'h02;
      l1_r <= '0;
      l2_r <= '0;
    end else begin
      s1_r <= {pcm_bclk, tx_frame_sync, rx_frame_sync, pcm_rx_data,
               control_clock, control_select_n, control_in};
      s2_r <= s1_r;
      s3_r <= s2_r;
      l1_r <= interface_latch_pin_in;
      l2_r <= l1_r;
    end
  end

  logic bclk_h;
  logic bclk_rise;
  logic bclk_fall;
  logic fsx_h;
  logic fsx_fall;
  logic fsr_h;
  logic rx_bit;
  logic control_clock_rise;
  logic control_clock_fall;
  logic cs_low;
  logic cs_fall;
  logic cs_rise;
  logic ci_bit;

  assign bclk_h    = s2_r[7];
  assign bclk_rise = s2_r[7] & ~s3_r[7];
  assign bclk_fall = ~s2_r[7] & s3_r[7];
  assign fsx_h     = s2_r[6];
  assign fsx_fall  = ~s2_r[6] & s3_r[6];
  assign fsr_h     = s2_r[5];
  assign rx_bit    = rx_port_sel ? s2_r[4] : s2_r[3];
  assign control_clock_rise = s2_r[2] & ~s3_r[2];
  assign control_clock_fall = ~s2_r[2] & s3_r[2];
  assign cs_low    = ~s2_r[1];
  assign cs_fall   = ~s2_r[1] & s3_r[1];
  assign cs_rise   = s2_r[1] & ~s3_r[1];
  assign ci_bit    = s2_r[0];

  // ---------------------------------------------------------------
  // Transmit path
  // ---------------------------------------------------------------
  logic [7:0] f_data;
  logic       f_valid;
  logic       tx_act_r;
  logic       tx_pend_r;
  logic       tx_arm_r;
  logic [3:0] tx_cnt_r;
  logic [7:0] tx_sh_r;
  logic [7:0] tx_load;
  logic       tx_start;
  logic       tx_rel;

  pcs_fifo #(.W(BYTE_W), .D(DEPTH)) u_fifo (
    .core_clk  (core_clk),
    .rstn      (rstn),
    .in_data   (tx_word),
    .in_valid  (tx_valid),
    .in_ready  (tx_ready),
    .out_data  (f_data),
    .out_valid (f_valid),
    .out_ready (tx_start)
  );

  // Slot start: both high, or rise after a sync seen in delayed mode
  assign tx_start = tx_arm_r & ~tx_act_r &
                    (delayed_mode ? (tx_pend_r & bclk_rise) : (bclk_h & fsx_h));
  assign tx_load  = f_valid ? f_data : IDLE_BYTE;
  // Release after bit eight
  assign tx_rel   = tx_act_r & (tx_cnt_r == BIT_LAST) &
                    ((bclk_fall & ~fsx_h) | (fsx_fall & ~bclk_h) | bclk_rise);

  // Slot sequencing and bit launch
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      tx_act_r            <= 1'b0;
      tx_pend_r           <= 1'b0;
      tx_arm_r            <= 1'b0;
      tx_cnt_r            <= '0;
      tx_sh_r             <= '0;
      pcm_tx_data         <= 1'b0;
      pcm_tx_data_oe_n    <= 1'b1;
      tx_slot_indicator_n <= 1'b1;
    end else begin
      if (!fsx_h && !tx_act_r) begin
        tx_arm_r <= 1'b1;
      end
      if (bclk_fall && fsx_h && tx_arm_r && !tx_act_r && delayed_mode) begin
        tx_pend_r <= 1'b1;
      end
      if (tx_start) begin
        tx_act_r            <= 1'b1;
        tx_arm_r            <= 1'b0;
        tx_pend_r           <= 1'b0;
        tx_cnt_r            <= 4'h1;
        pcm_tx_data         <= tx_load[7];
        tx_sh_r             <= {tx_load[6:0], 1'b0};
        pcm_tx_data_oe_n    <= 1'b0;
        tx_slot_indicator_n <= 1'b0;
      end else if (tx_rel) begin
        tx_act_r            <= 1'b0;
        pcm_tx_data_oe_n    <= 1'b1;
        tx_slot_indicator_n <= 1'b1;
      end else if (tx_act_r && bclk_rise) begin
        pcm_tx_data <= tx_sh_r[7];
        tx_sh_r     <= {tx_sh_r[6:0], 1'b0};
        tx_cnt_r    <= tx_cnt_r + 4'h1;
      end
    end
  end

  // ---------------------------------------------------------------
  // Receive path
  // ---------------------------------------------------------------
  logic       rx_act_r;
  logic       rx_arm_r;
  logic [3:0] rx_cnt_r;
  logic [7:0] rx_sh_r;
  logic [7:0] rx_nxt;

  assign rx_nxt = {rx_sh_r[6:0], rx_bit};

  // Capture on falling bit-clock edges
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      rx_act_r <= 1'b0;
      rx_arm_r <= 1'b0;
      rx_cnt_r <= '0;
      rx_sh_r  <= '0;
      rx_word  <= '0;
      rx_valid <= 1'b0;
    end else begin
      rx_valid <= 1'b0;
      if (!fsr_h && !rx_act_r) begin
        rx_arm_r <= 1'b1;
      end
      if (bclk_fall) begin
        if (!rx_act_r && fsr_h && rx_arm_r) begin
          rx_act_r <= 1'b1;
          rx_arm_r <= 1'b0;
          rx_cnt_r <= delayed_mode ? 4'h0 : 4'h1;
          rx_sh_r  <= rx_nxt;
        end else if (rx_act_r) begin
          rx_sh_r  <= rx_nxt;
          rx_cnt_r <= rx_cnt_r + 4'h1;
          if (rx_cnt_r == BIT_PENULT) begin
            rx_word  <= rx_nxt;
            rx_valid <= 1'b1;
            rx_act_r <= 1'b0;
          end
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // Control port
  // ---------------------------------------------------------------
  pcs_ctl_t   ctl_r;
  logic [3:0] fall_cnt_r;
  logic [3:0] rise_cnt_r;
  logic [7:0] in_sh_r;
  logic [7:0] out_sh_r;
  logic       pre_r;
  logic [7:0] in_nxt;
  logic       is_read;

  assign in_nxt  = {in_sh_r[6:0], ci_bit};
  // Single-byte commands never reach the output driver
  assign is_read = cmd_byte[CMD_READ_BIT] & ~cmd_byte[CMD_ONE_BIT];

  // Byte framing, latch access and output driver
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      ctl_r                   <= PCS_CTL_IDLE;
      fall_cnt_r              <= '0;
      rise_cnt_r              <= '0;
      in_sh_r                 <= '0;
      out_sh_r                <= '0;
      pre_r                   <= 1'b0;
      cmd_byte                <= '0;
      cmd_valid               <= 1'b0;
      ctl_wdata               <= '0;
      ctl_wvalid              <= 1'b0;
      control_out             <= 1'b0;
      control_out_oe_n        <= 1'b1;
      latch_sample            <= '0;
      interface_latch_pin_out <= '0;
    end else begin
      cmd_valid  <= 1'b0;
      ctl_wvalid <= 1'b0;
      if (cs_rise) begin
        control_out_oe_n <= 1'b1;
        pre_r            <= 1'b0;
        if (!(ctl_r == PCS_CTL_DATA && fall_cnt_r == '0 && rise_cnt_r == '0)) begin
          ctl_r <= PCS_CTL_IDLE;
        end
      end else if (cs_fall) begin
        if (ctl_r == PCS_CTL_DATA) begin
          if (is_read) begin
            control_out_oe_n <= 1'b0;
            control_out      <= out_sh_r[7];
            out_sh_r         <= {out_sh_r[6:0], 1'b0};
            pre_r            <= 1'b1;
          end
        end else begin
          ctl_r      <= PCS_CTL_CMD;
          fall_cnt_r <= '0;
        end
      end else if (cs_low) begin
        if (control_clock_fall && ctl_r == PCS_CTL_CMD) begin
          in_sh_r    <= in_nxt;
          fall_cnt_r <= fall_cnt_r + 4'h1;
          if (fall_cnt_r == BIT_PENULT) begin
            cmd_byte     <= in_nxt;
            cmd_valid    <= 1'b1;
            latch_sample <= l2_r & ~latch_dir;
            out_sh_r     <= ctl_resp;
            fall_cnt_r   <= '0;
            rise_cnt_r   <= '0;
            ctl_r        <= in_nxt[CMD_ONE_BIT] ? PCS_CTL_TAIL : PCS_CTL_DATA;
          end
        end else if (control_clock_fall && ctl_r == PCS_CTL_DATA) begin
          in_sh_r    <= in_nxt;
          fall_cnt_r <= fall_cnt_r + 4'h1;
          if (fall_cnt_r == BIT_PENULT) begin
            ctl_wdata  <= in_nxt;
            ctl_wvalid <= 1'b1;
            ctl_r      <= PCS_CTL_TAIL;
            if (!is_read) begin
              interface_latch_pin_out <= in_nxt[LN-1:0];
            end
          end
        end
        if (control_clock_rise && is_read &&
            (ctl_r == PCS_CTL_DATA || ctl_r == PCS_CTL_TAIL)) begin
          if (rise_cnt_r == BIT_LAST) begin
            control_out_oe_n <= 1'b1;
          end else if (rise_cnt_r < BIT_LAST) begin
            rise_cnt_r <= rise_cnt_r + 4'h1;
            pre_r      <= 1'b0;
            if (!pre_r) begin
              control_out_oe_n <= 1'b0;
              control_out      <= out_sh_r[7];
              out_sh_r         <= {out_sh_r[6:0], 1'b0};
            end
          end
        end
      end
    end
  end

  // Latch pin direction
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      interface_latch_pin_oe_n <= '1;
    end else begin
      interface_latch_pin_oe_n <= ~latch_dir;
    end
  end
endmodule // pcs_serial_port

/* File: hw/pcs_pkg.sv */
// Shared constants and types for the PCM and control serial port
package pcs_pkg;
  localparam int         BYTE_W       = 8;
  localparam int         FIFO_DEPTH   = 4;
  localparam int         LATCH_N      = 6;
  localparam logic [3:0] BIT_LAST     = 4'h8;
  localparam logic [3:0] BIT_PENULT   = 4'h7;
  localparam int         CMD_READ_BIT = 0;
  localparam int         CMD_ONE_BIT  = 1;
  localparam logic [7:0] IDLE_BYTE    = 8'hff;

  typedef enum logic [1:0] {
    PCS_CTL_IDLE = 2'b00,
    PCS_CTL_CMD  = 2'b01,
    PCS_CTL_DATA = 2'b10,
    PCS_CTL_TAIL = 2'b11
  } pcs_ctl_t;
endpackage

/* File: bench/pcs_serial_port_monitor.sv */
// Concurrent checks on the serial port pins and pulses
`timescale 1ns/1ps
module pcs_serial_port_chk
  import pcs_pkg::*;
#(
  parameter int LN = 6
) (
  input wire logic          core_clk,
  input wire logic          rstn,
  input wire logic          pcm_bclk,
  input wire logic          tx_frame_sync,
  input wire logic          delayed_mode,
  input wire logic          pcm_tx_data,
  input wire logic          pcm_tx_data_oe_n,
  input wire logic          tx_slot_indicator_n,
  input wire logic          rx_valid,
  input wire logic          control_clock,
  input wire logic          control_select_n,
  input wire logic          control_out,
  input wire logic          control_out_oe_n,
  input wire logic [7:0]    cmd_byte,
  input wire logic          cmd_valid,
  input wire logic          ctl_wvalid,
  input wire logic [LN-1:0] interface_latch_pin_out
);
  logic       pb_r, pc_r, rd_r, one_r;
  logic [3:0] sr_r, sf_r, fc_r, sc_r, cr_r;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);
  function automatic logic [3:0] inc(input logic [3:0] v);
    return (v == 4'hf) ? v : v + 4'h1;
  endfunction
  // ----------
  // Helper state
  // ----------
  // Bit clock edge ages and falls counted while driving
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      pb_r <= 1'b0; sr_r <= 4'hf; sf_r <= 4'hf; fc_r <= 4'h0;
    end else begin
      pb_r <= pcm_bclk;
      sr_r <= (pcm_bclk & ~pb_r) ? 4'h0 : inc(sr_r);
      sf_r <= (~pcm_bclk & pb_r) ? 4'h0 : inc(sf_r);
      fc_r <= pcm_tx_data_oe_n ? 4'h0 : fc_r + {3'h0, ~pcm_bclk & pb_r};
    end
  end
  // Control clock rise age, rises while driving, pending command kind
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      pc_r <= 1'b0; sc_r <= 4'hf; cr_r <= 4'h0; rd_r <= 1'b0; one_r <= 1'b0;
    end else begin
      pc_r <= control_clock;
      sc_r <= (control_clock & ~pc_r) ? 4'h0 : inc(sc_r);
      cr_r <= control_out_oe_n ? 4'h0 : cr_r + {3'h0, control_clock & ~pc_r};
      if (cmd_valid) begin
        rd_r  <= cmd_byte[CMD_READ_BIT] & ~cmd_byte[CMD_ONE_BIT];
        one_r <= cmd_byte[CMD_ONE_BIT];
      end else begin
        if (!control_out_oe_n) rd_r <= 1'b0;
        if (control_select_n) one_r <= 1'b0;
      end
    end
  end
  // ----------
  // Assertions
  // ----------
  a_tx_launch_rise: assert property (!pcm_tx_data_oe_n && !$past(pcm_tx_data_oe_n)
    && $changed(pcm_tx_data) |-> sr_r <= 4'h3) else $error("tx bit moved away from a rise");
  a_tx_eight_falls: assert property (fc_r == 4'h8 && !tx_frame_sync
    |-> ##[0:5] pcm_tx_data_oe_n) else $error("tx data kept after eighth fall");
  a_tx_no_ninth: assert property (fc_r < 4'h9) else $error("tx data held over nine falls");
  a_slot_tracks_drive: assert property (tx_slot_indicator_n == pcm_tx_data_oe_n)
    else $error("slot indicator differs from data drive");
  a_slot_starts: assert property (!delayed_mode && $rose(pcm_bclk && tx_frame_sync)
    |-> ##[1:5] !tx_slot_indicator_n) else $error("slot indicator late");
  a_rx_on_fall: assert property (rx_valid |-> sf_r <= 4'h3)
    else $error("rx word not tied to a fall");
  a_co_shift_rise: assert property (!control_out_oe_n && !$past(control_out_oe_n)
    && $changed(control_out) |-> sc_r <= 4'h3) else $error("control out moved off a rise");
  a_co_sel_float: assert property ($rose(control_select_n) |-> ##[1:5] control_out_oe_n)
    else $error("control out driven after select high");
  a_co_nine_rises: assert property (cr_r < 4'ha) else $error("control out past ninth rise");
  a_co_sel_start: assert property ($fell(control_select_n) && rd_r
    |-> ##[1:6] !control_out_oe_n) else $error("second select did not start drive");
  a_single_quiet: assert property (one_r |-> control_out_oe_n)
    else $error("control out driven for single byte");
  a_latch_update: assert property ($changed(interface_latch_pin_out)
    |-> ctl_wvalid || $past(ctl_wvalid)) else $error("latch outputs moved off byte two");
  c_tx_slot: cover property ($fell(pcm_tx_data_oe_n));
  c_write: cover property (ctl_wvalid);
  c_sep_read: cover property ($fell(control_select_n) && rd_r);
  c_single: cover property (one_r && control_select_n);
endmodule // pcs_serial_port_chk

bind pcs_serial_port pcs_serial_port_chk #(.LN(LN)) pcs_serial_port_chk_inst (.*);

/* File: bench/pcs_highway_model.sv */
// Highway model: bit clock, frame syncs, receive lanes, transmit capture
`timescale 1ns/1ps
module pcs_highway_model (
  input  wire logic       core_clk,
  input  wire logic       go,
  input  wire logic       late,
  input  wire logic       delayed_mode,
  input  wire logic       rx_port_sel,
  input  wire logic [7:0] rx_byte,
  input  wire logic       pcm_tx_data,
  input  wire logic       pcm_tx_data_oe_n,
  output logic            pcm_bclk,
  output logic            tx_frame_sync,
  output logic            rx_frame_sync,
  output logic [1:0]      pcm_rx_data,
  output logic [7:0]      tx_cap = 8'h00,
  output logic            busy = 1'b0
);
  logic [6:0] n_r = 7'h00;
  logic [6:0] m;
  logic [3:0] k;
  logic [3:0] c;
  logic       bit_v;
  assign m = n_r - 7'h02;
  assign k = m[6:3] - {3'h0, delayed_mode};
  assign c = n_r[6:3] - 4'h1 - {3'h0, delayed_mode};
  // Lane data moves mid-low, clear of the sampling fall; idle lanes toggle
  assign bit_v = (k < 4'h8) ? rx_byte[3'h7 - k[2:0]] : m[3];
  assign pcm_rx_data = rx_port_sel ? {bit_v, ~bit_v} : {~bit_v, bit_v};
  // 320 ns bit clock, still low between frames
  assign pcm_bclk = busy & n_r[2];
  // Sync held past the first fall; a late one rises after the clock
  assign tx_frame_sync = busy & (n_r >= (late ? 7'h05 : 7'h00)) & (n_r < 7'h0a);
  assign rx_frame_sync = tx_frame_sync;
  // Frame sequencing; tx bit taken one cycle after each of the eight falls in the slot
  always @(posedge core_clk) begin
    if (go && !busy) begin
      busy <= 1'b1;
    end else if (busy) begin
      n_r  <= (n_r == 7'h4f) ? 7'h00 : n_r + 7'h01;
      busy <= (n_r != 7'h4f);
      if (n_r[2:0] == 3'h0 && n_r != 7'h00 && c < 4'h8)
        tx_cap <= {tx_cap[6:0], pcm_tx_data_oe_n ? 1'bx : pcm_tx_data};
    end
  end
endmodule // pcs_highway_model

/* File: bench/pcs_serial_port_tb.sv */
// Self-checking bench for the PCM and control serial port
`timescale 1ns/1ps
module pcs_serial_port_tb;
  import pcs_pkg::*;
  localparam int LN = LATCH_N;
  logic          core_clk = 1'b0, rstn = 1'b0, tx_valid = 1'b0, go = 1'b0, late = 1'b0;
  logic          delayed_mode = 1'b0, rx_port_sel = 1'b0, control_clock = 1'b0;
  logic          control_select_n = 1'b1, control_in = 1'b0;
  logic [7:0]    tx_word = 8'h00, ctl_resp = 8'h00, rx_byte = 8'h00;
  logic [LN-1:0] latch_dir = '0, interface_latch_pin_in = '0;
  logic          pcm_bclk, tx_frame_sync, rx_frame_sync, pcm_tx_data, pcm_tx_data_oe_n;
  logic          tx_slot_indicator_n, tx_ready, rx_valid, control_out, control_out_oe_n;
  logic          cmd_valid, ctl_wvalid, busy;
  logic [1:0]    pcm_rx_data;
  logic [7:0]    rx_word, cmd_byte, ctl_wdata, tx_cap, rx_got, cmd_got, wd_got;
  logic [LN-1:0] interface_latch_pin_out, interface_latch_pin_oe_n, latch_sample;
  logic [31:0]   r;
  logic [7:0]    exp_q[$];
  integer        seed = 36771;
  int            failures = 0, checks_done = 0, i;
  always #20 core_clk = ~core_clk;
  pcs_serial_port #(.DEPTH(FIFO_DEPTH), .LN(LN)) pcs_serial_port_inst (.*);
  pcs_highway_model pcs_highway_model_inst (.*);
  // Hold the one-cycle pulses
  always @(posedge core_clk) begin
    if (rx_valid === 1'b1) rx_got <= rx_word;
    if (cmd_valid === 1'b1) cmd_got <= cmd_byte;
    if (ctl_wvalid === 1'b1) wd_got <= ctl_wdata;
  end
  // ----------
  // Tasks
  // ----------
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Expected latch view, padded to a byte
  function automatic logic [7:0] lat8(input logic [LN-1:0] v);
    return {{(8 - LN){1'b0}}, v};
  endfunction
  task automatic push(input logic [7:0] w);
    int n;
    logic rdy;
    tx_word <= w;
    tx_valid <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(negedge core_clk);
      rdy = tx_ready;
      @(posedge core_clk);
      if (rdy === 1'b1) break;
    end
    if (n == 50) begin failures++; results(); end
    exp_q.push_back(w);
  endtask
  task automatic frame(input logic d, input logic l, input logic [7:0] exp);
    int n;
    r = $random(seed);
    delayed_mode <= d;
    late <= ~d & l;
    rx_port_sel <= r[1];
    rx_byte <= r[15:8];
    rx_got = 8'hxx;
    cyc(2);
    go <= 1'b1;
    cyc(1);
    go <= 1'b0;
    cyc(2);
    for (n = 0; n < 200 && busy === 1'b1; n++) cyc(1);
    if (busy === 1'b1) begin failures++; results(); end
    cyc(6);
    chk(tx_cap, exp);
    chk(rx_got, r[15:8]);
    chk({6'h00, pcm_tx_data_oe_n, tx_slot_indicator_n}, 8'h03);
  endtask
  // Host side byte: data moves mid-low, reply taken just before each fall
  task automatic cbyte(input logic [7:0] b, output logic [7:0] rd);
    for (int n = 7; n >= 0; n--) begin
      cyc(2);
      control_in <= b[n];
      cyc(2);
      control_clock <= 1'b1;
      cyc(4);
      rd[n] = control_out_oe_n ? 1'bx : control_out;
      control_clock <= 1'b0;
    end
    cyc(6);
  endtask
  // Kinds: 0 write, 1 read, 2 single byte, 3 read with its own select
  task automatic xfer(input logic [1:0] kind);
    logic [7:0] cmd, wd, rd;
    r = $random(seed);
    cmd = {r[7:2], kind == 2'h2, kind[0]};
    wd = r[15:8];
    ctl_resp <= r[23:16];
    latch_dir <= r[24 +: LN];
    r = $random(seed);
    interface_latch_pin_in <= r[0 +: LN];
    cmd_got = 8'hxx;
    wd_got = 8'hxx;
    cyc(6);
    control_select_n <= 1'b0;
    cyc(4);
    cbyte(cmd, rd);
    chk(cmd_got, cmd);
    chk(rd, 8'hxx);
    chk({2'h0, latch_sample}, {2'h0, interface_latch_pin_in & ~latch_dir});
    chk({2'h0, interface_latch_pin_oe_n}, {2'h0, ~latch_dir});
    if (kind != 2'h2) begin
      if (kind == 2'h3) begin
        control_select_n <= 1'b1;
        cyc(8);
        control_select_n <= 1'b0;
        cyc(4);
      end
      cbyte(wd, rd);
      if (kind[0]) begin
        chk(rd, ctl_resp);
        control_clock <= 1'b1;
        cyc(6);
        chk({7'h00, control_out_oe_n}, 8'h01);
        control_clock <= 1'b0;
        cyc(2);
      end else begin
        chk(wd_got, wd);
        chk(lat8(interface_latch_pin_out), lat8(wd[LN-1:0]));
      end
    end
    control_select_n <= 1'b1;
    control_in <= ~control_in;
    cyc(8);
    if (kind == 2'h2) chk(wd_got, 8'hxx);
  endtask
  // ----------
  // Main sequence
  // ----------
  initial begin
    cyc(4);
    rstn <= 1'b1;
    cyc(6);
    for (i = 0; i < FIFO_DEPTH; i++) push($random(seed));
    tx_valid <= 1'b0;
    cyc(2);
    chk({7'h00, tx_ready}, 8'h00);
    for (i = 0; i <= FIFO_DEPTH; i++)
      frame(i[0], i[1], (i < FIFO_DEPTH) ? exp_q.pop_front() : IDLE_BYTE);
    for (i = 0; i < 12; i++) xfer(i[1:0]);
    results();
  end
endmodule // pcs_serial_port_tb
